// File: rtl/drpvc_pkg.sv
// Constants, field layouts and carrier types for the dual-rail phase/voltage slice.
// Assumes an AXI4-Lite master with 32-bit data and 12-bit byte addresses.
package drpvc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] PHASE_CONFIG_IDX = 8'hd3;
  localparam logic [7:0] RAIL_MODE_IDX = 8'hd4;
  localparam logic [7:0] RAIL_A_CEILING_IDX = 8'hd5;
  localparam logic [7:0] RAIL_B_CEILING_IDX = 8'hd6;
  localparam logic [7:0] RAIL_A_SET_A_IDX = 8'hd7;
  localparam logic [7:0] RAIL_A_SET_B_IDX = 8'hd8;
  localparam logic [7:0] RAIL_B_SET_A_IDX = 8'hd9;
  localparam logic [7:0] RAIL_B_SET_B_IDX = 8'hda;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int SHED_B_BIT = 4;
  localparam int SHED_A_BIT = 3;
  localparam int PHASE_B_BIT = 2;
  localparam int PHASE_A_LSB = 0;
  localparam int MODE_A_LSB = 0;
  localparam int MODE_B_LSB = 2;
  localparam int AUTO_BIT = 7;
  localparam int CODE_W = 7;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_BY_SETTING = 2'h0;
  localparam logic [1:0] MODE_FORCE_PWM = 2'h2;
  localparam logic [1:0] PHASE_CODE_TWO = 2'h1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] CODE_RESET = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selector produced by the address decoder
  typedef enum {
    DRPVC_SEL_NONE,
    DRPVC_SEL_PHASE,
    DRPVC_SEL_MODE,
    DRPVC_SEL_CEIL_A,
    DRPVC_SEL_CEIL_B,
    DRPVC_SEL_A_SET_A,
    DRPVC_SEL_A_SET_B,
    DRPVC_SEL_B_SET_A,
    DRPVC_SEL_B_SET_B
  } drpvc_sel_t;

  // Per-rail state presented to the regulator
  typedef struct packed {
    logic [6:0] code;
    logic auto_mode;
    logic [2:0] phases;
    logic shed_enable;
  } drpvc_rail_t;

  // One voltage setting: mode bit plus target code
  typedef struct packed {
    logic auto_mode;
    logic [6:0] code;
  } drpvc_setting_t;

endpackage : drpvc_pkg

// File: rtl/drpvc_top.sv
// Configuration register slice for two multi-phase step-down rails, A and B.
// Assumes an AXI4-Lite master on clk_in; setting selects, test mode and variant
// strap arrive from pins; the ceiling load strobe comes from logic on clk_in.
//
// What this block does
// [RULE_01] Phase config bit 4 enables rail B phase shedding in PWM.
// [RULE_02] Phase config bit 3 enables rail A phase shedding in PWM.
// [RULE_03] Phase config bit 2 picks rail B one or two PWM phases.
// [RULE_04] Phase config bits 1:0 pick rail A one to four PWM phases.
// [RULE_05] Rail A codes above 01 act only on four-phase variant, else two.
// [RULE_06] Rail A read-only 7-bit voltage ceiling, loaded from OTP, test mode only.
// [RULE_07] Rail B read-only 7-bit voltage ceiling, same scale, test mode only.
// [RULE_08] Rail A setting A holds code 6:0; bit 7 selects PWM or automatic.
// [RULE_09] Rail A setting B holds code 6:0; bit 7 selects PWM or automatic.
// [RULE_10] Rail B setting A bit 7 selects operating style; zero forces PWM.
// [RULE_11] Mode field 00 follows the selected setting's mode bit; others override.
// [RULE_12] Rail B mode field 10 forces PWM, 01 selects automatic.
// [RULE_13] Each rail outputs active code, clamped to its ceiling, and mode from setting select input.
// [RULE_14] Reserved bits read zero, ignore writes; fields reset to zero.
`timescale 1ns/1ps

module drpvc_top
  import drpvc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins
  input wire logic rail_a_sel_b_in,
  input wire logic rail_b_sel_b_in,
  input wire logic test_mode_in,
  input wire logic four_phase_variant_in,
  // One-time-programmable ceiling load, same clock
  input wire logic otp_load_in,
  input wire logic [6:0] otp_rail_a_ceiling_in,
  input wire logic [6:0] otp_rail_b_ceiling_in,
  // Regulator controls
  output drpvc_rail_t rail_a_out,
  output drpvc_rail_t rail_b_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic drpvc_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    drpvc_sel_t sel;
    sel = DRPVC_SEL_NONE;
    if (addr[ADDR_W-1:10] == 2'h0)
    begin
      unique case (addr[9:2])
        PHASE_CONFIG_IDX: sel = DRPVC_SEL_PHASE;
        RAIL_MODE_IDX: sel = DRPVC_SEL_MODE;
        RAIL_A_CEILING_IDX: sel = DRPVC_SEL_CEIL_A;
        RAIL_B_CEILING_IDX: sel = DRPVC_SEL_CEIL_B;
        RAIL_A_SET_A_IDX: sel = DRPVC_SEL_A_SET_A;
        RAIL_A_SET_B_IDX: sel = DRPVC_SEL_A_SET_B;
        RAIL_B_SET_A_IDX: sel = DRPVC_SEL_B_SET_A;
        RAIL_B_SET_B_IDX: sel = DRPVC_SEL_B_SET_B;
        default: sel = DRPVC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decode_addr

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Order: rail A select, rail B select, test mode, variant strap
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_raw;

  assign pin_raw = {four_phase_variant_in, test_mode_in, rail_b_sel_b_in, rail_a_sel_b_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end
        else if (ce_in)
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic a_sel_b;
  logic b_sel_b;
  logic test_mode;
  logic four_phase;

  assign a_sel_b = pin_sync[0];
  assign b_sel_b = pin_sync[1];
  assign test_mode = pin_sync[2];
  assign four_phase = pin_sync[3];

  // ----------------------------------------------------------------
  // Bus handshake state
  // ----------------------------------------------------------------
  logic aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane0;
  logic next_aw_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic next_w_held;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  drpvc_sel_t wr_sel;
  drpvc_sel_t rd_sel;

  // ----------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------
  logic [4:0] phase_config;
  logic [3:0] rail_mode;
  logic [6:0] ceil_a;
  logic [6:0] ceil_b;
  drpvc_setting_t a_set_a;
  drpvc_setting_t a_set_b;
  drpvc_setting_t b_set_a;
  drpvc_setting_t b_set_b;
  logic [4:0] next_phase_config;
  logic [3:0] next_rail_mode;
  logic [6:0] next_ceil_a;
  logic [6:0] next_ceil_b;
  drpvc_setting_t next_a_set_a;
  drpvc_setting_t next_a_set_b;
  drpvc_setting_t next_b_set_a;
  drpvc_setting_t next_b_set_b;
  drpvc_rail_t next_rail_a;
  drpvc_rail_t next_rail_b;
  logic [7:0] rd_byte;

  assign wr_sel = decode_addr(aw_addr);
  assign rd_sel = decode_addr(s_axi_araddr_in);
  // A write completes once address and data are both held and the response slot is free
  assign do_write = aw_held && w_held && !s_axi_bvalid_out;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid_out;
    next_bresp = s_axi_bresp_out;
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata_in[7:0];
      next_w_lane0 = s_axi_wstrb_in[0];
    end
    if (s_axi_bvalid_out && s_axi_bready_in)
      next_bvalid = 1'b0;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wr_sel == DRPVC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;

    next_rvalid = s_axi_rvalid_out;
    next_rdata = s_axi_rdata_out;
    next_rresp = s_axi_rresp_out;
    if (s_axi_rvalid_out && s_axi_rready_in)
      next_rvalid = 1'b0;
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, rd_byte};
      next_rresp = (rd_sel == DRPVC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    next_arready = !next_rvalid;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_byte = REG_RESET;
    unique case (rd_sel)
      // [RULE_14] Reserved bits zero
      DRPVC_SEL_PHASE: rd_byte = {3'h0, phase_config};
      DRPVC_SEL_MODE: rd_byte = {4'h0, rail_mode};
      // [RULE_06] Ceiling hidden outside test
      DRPVC_SEL_CEIL_A: rd_byte = test_mode ? {1'b0, ceil_a} : REG_RESET;
      // [RULE_07] Ceiling hidden outside test
      DRPVC_SEL_CEIL_B: rd_byte = test_mode ? {1'b0, ceil_b} : REG_RESET;
      DRPVC_SEL_A_SET_A: rd_byte = a_set_a;
      DRPVC_SEL_A_SET_B: rd_byte = a_set_b;
      DRPVC_SEL_B_SET_A: rd_byte = b_set_a;
      DRPVC_SEL_B_SET_B: rd_byte = b_set_b;
      DRPVC_SEL_NONE: rd_byte = REG_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes and ceiling load
  // ----------------------------------------------------------------
  always_comb
  begin
    next_phase_config = phase_config;
    next_rail_mode = rail_mode;
    next_a_set_a = a_set_a;
    next_a_set_b = a_set_b;
    next_b_set_a = b_set_a;
    next_b_set_b = b_set_b;
    next_ceil_a = ceil_a;
    next_ceil_b = ceil_b;
    if (do_write && w_lane0)
    begin
      unique case (wr_sel)
        // [RULE_14] Reserved bits dropped
        DRPVC_SEL_PHASE: next_phase_config = w_byte[4:0];
        DRPVC_SEL_MODE: next_rail_mode = w_byte[3:0];
        // [RULE_08] Setting A stored
        DRPVC_SEL_A_SET_A: next_a_set_a = w_byte;
        // [RULE_09] Setting B stored
        DRPVC_SEL_A_SET_B: next_a_set_b = w_byte;
        // [RULE_10] Rail B setting
        DRPVC_SEL_B_SET_A: next_b_set_a = w_byte;
        DRPVC_SEL_B_SET_B: next_b_set_b = w_byte;
        DRPVC_SEL_CEIL_A,
        DRPVC_SEL_CEIL_B,
        DRPVC_SEL_NONE: next_phase_config = phase_config;
      endcase
    end
    // [RULE_06] OTP load rail A
    if (otp_load_in)
      next_ceil_a = otp_rail_a_ceiling_in;
    // [RULE_07] OTP load rail B
    if (otp_load_in)
      next_ceil_b = otp_rail_b_ceiling_in;
  end

  // ----------------------------------------------------------------
  // Rail outputs
  // ----------------------------------------------------------------
  // Active mode: setting bit when the field is by-setting, PWM when forced, else automatic
  function automatic logic pick_auto(input logic [1:0] field, input logic set_bit);
    logic res;
    res = 1'b1;
    if (field == MODE_BY_SETTING)
      res = set_bit;
    else if (field == MODE_FORCE_PWM)
      res = 1'b0;
    return res;
  endfunction : pick_auto

  // The target is clamped to the ceiling so software cannot exceed the allowed voltage
  function automatic logic [6:0] clamp_code(input logic [6:0] code, input logic [6:0] ceil);
    return (code > ceil) ? ceil : code;
  endfunction : clamp_code

  drpvc_setting_t a_active;
  drpvc_setting_t b_active;

  always_comb
  begin
    // [RULE_13] Select active setting
    a_active = a_sel_b ? a_set_b : a_set_a;
    b_active = b_sel_b ? b_set_b : b_set_a;
    next_rail_a.code = clamp_code(a_active.code, ceil_a);
    next_rail_b.code = clamp_code(b_active.code, ceil_b);
    // [RULE_11] Mode field override
    next_rail_a.auto_mode = pick_auto(rail_mode[MODE_A_LSB+:2], a_active.auto_mode);
    // [RULE_12] Rail B forced modes
    next_rail_b.auto_mode = pick_auto(rail_mode[MODE_B_LSB+:2], b_active.auto_mode);
    // [RULE_04] Rail A phase count
    next_rail_a.phases = 3'(phase_config[PHASE_A_LSB+:2]) + 3'h1;
    // [RULE_05] Cap at two phases
    if (!four_phase && phase_config[PHASE_A_LSB+:2] > PHASE_CODE_TWO)
      next_rail_a.phases = 3'h2;
    // [RULE_03] Rail B phase count
    next_rail_b.phases = phase_config[PHASE_B_BIT] ? 3'h2 : 3'h1;
    // [RULE_02] Rail A shedding
    next_rail_a.shed_enable = phase_config[SHED_A_BIT];
    // [RULE_01] Rail B shedding
    next_rail_b.shed_enable = phase_config[SHED_B_BIT];
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_byte <= REG_RESET;
      w_lane0 <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= RESP_OKAY;
      // [RULE_14] Fields reset zero
      phase_config <= 5'h00;
      rail_mode <= 4'h0;
      ceil_a <= CODE_RESET;
      ceil_b <= CODE_RESET;
      a_set_a <= REG_RESET;
      a_set_b <= REG_RESET;
      b_set_a <= REG_RESET;
      b_set_b <= REG_RESET;
      rail_a_out <= '0;
      rail_b_out <= '0;
    end
    else if (ce_in)
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      s_axi_awready_out <= next_awready;
      s_axi_wready_out <= next_wready;
      s_axi_bvalid_out <= next_bvalid;
      s_axi_bresp_out <= next_bresp;
      s_axi_arready_out <= next_arready;
      s_axi_rvalid_out <= next_rvalid;
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_rresp;
      phase_config <= next_phase_config;
      rail_mode <= next_rail_mode;
      ceil_a <= next_ceil_a;
      ceil_b <= next_ceil_b;
      a_set_a <= next_a_set_a;
      a_set_b <= next_a_set_b;
      b_set_a <= next_b_set_a;
      b_set_b <= next_b_set_b;
      rail_a_out <= next_rail_a;
      rail_b_out <= next_rail_b;
    end
  end

endmodule : drpvc_top

// File: tb/drpvc_assertions.sv
// Checker for the slice's bus handshakes and rail outputs.
// Assumes ce_in stays high while checked; bound to drpvc_top.
`timescale 1ns/1ps

module drpvc_assertions
  import drpvc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic four_phase_variant_in,
  input wire drpvc_rail_t rail_a_out,
  input wire drpvc_rail_t rail_b_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  AST_WRITE_WALK: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |=> !s_axi_awready_out && !s_axi_wready_out ##1 s_axi_bvalid_out)
    else $error("write response not two cycles after address and data");
  AST_READ_ANSWER: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  AST_B_STANDS: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before bready");
  AST_R_STANDS: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
    else $error("read answer dropped before rready");
  AST_AR_BLOCKED: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("arready high while answer pending");
  AST_B_CAUSE: assert property ($rose(s_axi_bvalid_out)
    |-> $past(!s_axi_awready_out && !s_axi_wready_out))
    else $error("write response without a taken write");
  AST_RDATA_UPPER: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_SLVERR_ZERO: assert property (s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR
    |-> s_axi_rdata_out == 32'h0)
    else $error("error read returned data");

  // ----------------------------------------------------------------
  // Phase counts; phases is zero only in the edge after reset
  // ----------------------------------------------------------------
  AST_PHASE_B: assert property (!$past(rst_in) |-> rail_b_out.phases inside {3'h1, 3'h2})
    else $error("rail b phase count out of range");
  AST_PHASE_CAP: assert property (!four_phase_variant_in [*5] |-> rail_a_out.phases <= 3'h2)
    else $error("rail a above two phases without strap");
endmodule : drpvc_assertions

bind drpvc_top drpvc_assertions u_chk (.clk_in, .rst_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .four_phase_variant_in, .rail_a_out, .rail_b_out);

// File: tb/tb_top.sv
// Self-checking bench for the slice against a register model.
// Assumes ce_in high throughout; pins settle within five cycles.
`timescale 1ns/1ps

module tb_top;
  import drpvc_pkg::*;
  logic clk_in, rst_in, ce_in;
  logic [ADDR_W-1:0] aw_a, ar_a;
  logic aw_v, w_v, b_rdy, ar_v, r_rdy, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [31:0] w_d, r_d;
  logic [3:0] w_s;
  logic [1:0] b_resp, r_resp;
  logic sel_a, sel_b, tmode, strap, otp_ld;
  logic [6:0] otp_a, otp_b;
  drpvc_rail_t rail_a, rail_b;
  int mismatches, tests_run, seed, ceil_a, ceil_b;
  int mem[8];
  int mask[8] = '{'h1f, 'h0f, 0, 0, 'hff, 'hff, 'hff, 'hff};

  drpvc_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_rdy),
    .s_axi_wdata_in(w_d), .s_axi_wstrb_in(w_s), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v),
    .s_axi_bready_in(b_rdy), .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_resp),
    .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_rdy), .rail_a_sel_b_in(sel_a),
    .rail_b_sel_b_in(sel_b), .test_mode_in(tmode), .four_phase_variant_in(strap),
    .otp_load_in(otp_ld), .otp_rail_a_ceiling_in(otp_a), .otp_rail_b_ceiling_in(otp_b),
    .rail_a_out(rail_a), .rail_b_out(rail_b));

  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------
  // Compare, bus and model helpers
  // ----------------------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_rail(input string what, input logic [11:0] exp, input drpvc_rail_t got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_rail

  task automatic bus_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    @(posedge clk_in);
    aw_a <= a;
    w_d <= d;
    w_s <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'($random(seed));
    do
    begin
      @(posedge clk_in);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
      if (!b_rdy) b_rdy <= 1'b1;
    end while (!(b_v === 1'b1 && b_rdy));
    r = b_resp;
    b_rdy <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'($random(seed));
    do
    begin
      @(posedge clk_in);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
      if (!r_rdy) r_rdy <= 1'b1;
    end while (!(r_v === 1'b1 && r_rdy));
    d = r_d;
    r = r_resp;
    r_rdy <= 1'b0;
  endtask : bus_read

  // Index k runs 0xd2..0xdb; both ends are unmapped
  task automatic check_reg(input int k);
    logic [31:0] d;
    logic [1:0] r;
    int e;
    bus_read(12'(12'h348 + k * 4), d, r);
    e = (k == 3) ? (tmode ? ceil_a : 0) : (k == 4) ? (tmode ? ceil_b : 0) :
      (k == 0 || k == 9) ? 0 : mem[k - 1];
    chk_word("read data", 32'(e), d);
    chk_word("read resp", (k == 0 || k == 9) ? RESP_SLVERR : RESP_OKAY, 32'(r));
  endtask : check_reg

  function automatic logic [11:0] exp_rail(input bit rb);
    int s, md, ph, code, cv;
    logic auto_v;
    s = rb ? (sel_b ? mem[7] : mem[6]) : (sel_a ? mem[5] : mem[4]);
    md = rb ? (mem[1] >> 2) & 3 : mem[1] & 3;
    auto_v = (md == 0) ? s[7] : (md != 2);
    ph = rb ? (mem[0][2] ? 2 : 1) : ((!strap && (mem[0] & 3) > 1) ? 2 : (mem[0] & 3) + 1);
    cv = rb ? ceil_b : ceil_a;
    code = ((s & 'h7f) < cv) ? (s & 'h7f) : cv;
    return {code[6:0], auto_v, ph[2:0], rb ? mem[0][4] : mem[0][3]};
  endfunction : exp_rail

  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #60000;
    mismatches++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence: two passes, the second after a mid-run reset
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] r;
    int k;
    seed = 55;
    {mismatches, tests_run} = 0;
    {ce_in, rst_in} = 2'b11;
    {aw_a, ar_a, w_d, w_s} = 0;
    {aw_v, w_v, b_rdy, ar_v, r_rdy, sel_a, sel_b, tmode, strap, otp_ld} = 0;
    {otp_a, otp_b} = 0;
    for (int pass = 0; pass < 2; pass++)
    begin
      rst_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      mem = '{default: 0};
      {ceil_a, ceil_b} = 0;
      for (int i = 0; i < 10; i++) check_reg(i);
      ceil_a = $random(seed) & 'h7f;
      ceil_b = $random(seed) & 'h7f;
      @(posedge clk_in);
      otp_a <= ceil_a[6:0];
      otp_b <= ceil_b[6:0];
      otp_ld <= 1'b1;
      @(posedge clk_in);
      otp_ld <= 1'b0;
      for (int n = 0; n < 60; n++)
      begin
        k = ($random(seed) & 'hffff) % 10;
        d = $random(seed);
        s = 4'($random(seed));
        bus_write(12'(12'h348 + k * 4), d, s, r);
        chk_word("write resp", (k == 0 || k == 9) ? RESP_SLVERR : RESP_OKAY, 32'(r));
        if (k >= 1 && k <= 8 && s[0]) mem[k - 1] = d & mask[k - 1];
        check_reg(k);
        @(posedge clk_in);
        {sel_a, sel_b, tmode, strap} <= 4'($random(seed));
        repeat (5) @(posedge clk_in);
        chk_rail("rail a", exp_rail(1'b0), rail_a);
        chk_rail("rail b", exp_rail(1'b1), rail_b);
      end
    end
    report_and_stop();
  end
endmodule : tb_top
